// ---- rtl/pcsamr_mgmt_regs.sv ----
// serial management frame decoder and coding sublayer register bank
`timescale 1ns/10ps
`default_nettype none
module pcsamr_mgmt_regs (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          tenBitPhyMode,
  input  wire logic                          serialMgmtClockBit,
  input  wire logic                          serialMgmtIoIn,
  input  wire logic                          serialMgmtDriveBit,
  input  wire pcsamr_pkg::pcsamr_status_type pcsStatus,
  output logic                               serialMgmtIoOut,
  output logic                               serialMgmtIoOe,
  output pcsamr_pkg::pcsamr_cfg_type         pcsConfig
);

  pcsamr_pkg::pcsamr_frame_type s_reg;
  pcsamr_pkg::pcsamr_frame_type s_next;

  logic        clkRise;
  logic        clkFall;
  logic [15:0] rdData;
  logic        respond;
  logic        wrHit;
  logic [15:0] wrValue;
  logic [15:0] ctrlWord;

  pcsamr_edge u_edge (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .mgmtClock (serialMgmtClockBit),
    .clkRise   (clkRise),
    .clkFall   (clkFall)
  );

  pcsamr_rdmux u_rdmux (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .rdStb     (s_reg.rdStb),
    .rdAddr    (s_reg.regAddr),
    .ctrl      (s_reg.ctrl),
    .advert    (s_reg.advert),
    .local_extra_page_tx  (s_reg.local_extra_page_tx),
    .pcsStatus (pcsStatus),
    .rdData    (rdData)
  );

  // answer only our own address, and only in ten-bit mode
  assign respond = tenBitPhyMode && (s_reg.phyAddr == pcsamr_pkg::PHY_ADDR)
                   && s_reg.isRead;
  assign wrValue = {s_reg.shiftIn[14:0], serialMgmtIoIn};
  assign wrHit   = clkRise && (s_reg.phase == pcsamr_pkg::PH_DATA) && (s_reg.bitCnt == 6'h0F)
                   && !s_reg.isRead && tenBitPhyMode
                   && (s_reg.phyAddr == pcsamr_pkg::PHY_ADDR);

  // self-clearing bits are never stored, so they read back as zero
  always_comb begin
    ctrlWord = (s_reg.ctrl & ~pcsamr_pkg::CTRL_WR_MASK) | (wrValue & pcsamr_pkg::CTRL_WR_MASK);
    ctrlWord[pcsamr_pkg::CTRL_RESET_BIT]   = 1'b0;
    ctrlWord[pcsamr_pkg::CTRL_RESTART_BIT] = 1'b0;
  end

  always_comb begin
    s_next           = s_reg;
    s_next.rdStb     = 1'b0;
    s_next.pcsReset  = 1'b0;
    s_next.anRestart = 1'b0;

    // frame decode on the rising edge of the management clock
    if (clkRise) begin
      case (s_reg.phase)
        pcsamr_pkg::PH_PRE: begin
          if (serialMgmtIoIn) begin
            if (s_reg.bitCnt < pcsamr_pkg::PREAMBLE_LEN) begin
              s_next.bitCnt = s_reg.bitCnt + 6'h01;
            end
          end else if (s_reg.bitCnt >= pcsamr_pkg::PREAMBLE_LEN) begin
            s_next.phase  = pcsamr_pkg::PH_START;
            s_next.bitCnt = 6'h00;
          end else begin
            s_next.bitCnt = 6'h00;
          end
        end
        pcsamr_pkg::PH_START: begin
          s_next.bitCnt = 6'h00;
          s_next.phase  = serialMgmtIoIn ? pcsamr_pkg::PH_OP : pcsamr_pkg::PH_PRE;
        end
        pcsamr_pkg::PH_OP: begin
          s_next.opCode = {s_reg.opCode[0], serialMgmtIoIn};
          if (s_reg.bitCnt == 6'h01) begin
            s_next.phase  = pcsamr_pkg::PH_PHY;
            s_next.bitCnt = 6'h00;
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 6'h01;
          end
        end
        pcsamr_pkg::PH_PHY: begin
          s_next.phyAddr = {s_reg.phyAddr[3:0], serialMgmtIoIn};
          if (s_reg.bitCnt == 6'h04) begin
            s_next.phase  = pcsamr_pkg::PH_REG;
            s_next.bitCnt = 6'h00;
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 6'h01;
          end
        end
        pcsamr_pkg::PH_REG: begin
          s_next.regAddr = {s_reg.regAddr[3:0], serialMgmtIoIn};
          if (s_reg.bitCnt == 6'h04) begin
            s_next.bitCnt = 6'h00;
            s_next.isRead = (s_reg.opCode == pcsamr_pkg::OP_READ);
            s_next.rdStb  = (s_reg.opCode == pcsamr_pkg::OP_READ);
            // an illegal opcode abandons the frame
            if ((s_reg.opCode == pcsamr_pkg::OP_READ) || (s_reg.opCode == pcsamr_pkg::OP_WRITE)) begin
              s_next.phase = pcsamr_pkg::PH_TA;
            end else begin
              s_next.phase = pcsamr_pkg::PH_PRE;
            end
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 6'h01;
          end
        end
        pcsamr_pkg::PH_TA: begin
          if (s_reg.bitCnt == 6'h01) begin
            s_next.phase  = pcsamr_pkg::PH_DATA;
            s_next.bitCnt = 6'h00;
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 6'h01;
          end
        end
        pcsamr_pkg::PH_DATA: begin
          s_next.shiftIn = wrValue;
          if (s_reg.bitCnt == 6'h0F) begin
            s_next.phase  = pcsamr_pkg::PH_PRE;
            s_next.bitCnt = 6'h00;
          end else begin
            s_next.bitCnt = s_reg.bitCnt + 6'h01;
          end
        end
        default: begin
          s_next.phase  = pcsamr_pkg::PH_PRE;
          s_next.bitCnt = 6'h00;
        end
      endcase
    end

    // read data change on the falling edge so the host samples on the rise
    if (clkFall) begin
      if ((s_reg.phase == pcsamr_pkg::PH_TA) && (s_reg.bitCnt == 6'h01) && respond) begin
        s_next.dataOe  = 1'b1;
        s_next.dataOut = 1'b0;
      end else if ((s_reg.phase == pcsamr_pkg::PH_DATA) && respond) begin
        s_next.dataOe  = 1'b1;
        s_next.dataOut = rdData[4'hF - s_reg.bitCnt[3:0]];
      end else begin
        s_next.dataOe  = 1'b0;
        s_next.dataOut = 1'b0;
      end
    end
    // never fight the host, and stay silent outside ten-bit mode
    if (!tenBitPhyMode || serialMgmtDriveBit) begin
      s_next.dataOe = 1'b0;
    end

    // register writes at the last data bit of a write frame
    if (wrHit) begin
      case (s_reg.regAddr)
        pcsamr_pkg::ADDR_CTRL: begin
          if (wrValue[pcsamr_pkg::CTRL_RESET_BIT]) begin
            s_next.ctrl     = pcsamr_pkg::RST_CTRL;
            s_next.advert   = pcsamr_pkg::RST_ADVERT;
            s_next.local_extra_page_tx = pcsamr_pkg::RST_NPAGE;
            s_next.pcsReset = 1'b1;
          end else begin
            s_next.ctrl      = ctrlWord;
            s_next.anRestart = wrValue[pcsamr_pkg::CTRL_RESTART_BIT];
          end
        end
        pcsamr_pkg::ADDR_ADVERT: begin
          // reserved bits keep their stored zeros
          s_next.advert = (s_reg.advert & ~pcsamr_pkg::ADV_WR_MASK)
                          | (wrValue & pcsamr_pkg::ADV_WR_MASK);
        end
        pcsamr_pkg::ADDR_NPAGE: begin
          s_next.local_extra_page_tx = wrValue;
        end
        default: begin
          s_next.ctrl = s_reg.ctrl;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg          <= '0;
      s_reg.phase    <= pcsamr_pkg::PH_PRE;
      s_reg.ctrl     <= pcsamr_pkg::RST_CTRL;
      s_reg.advert   <= pcsamr_pkg::RST_ADVERT;
      s_reg.local_extra_page_tx <= pcsamr_pkg::RST_NPAGE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign serialMgmtIoOut         = s_reg.dataOut;
  assign serialMgmtIoOe          = s_reg.dataOe;
  assign pcsConfig.pcsReset      = s_reg.pcsReset;
  assign pcsConfig.anRestart     = s_reg.anRestart;
  assign pcsConfig.anEnable      = s_reg.ctrl[pcsamr_pkg::CTRL_ANEN_BIT];
  assign pcsConfig.loopback      = s_reg.ctrl[pcsamr_pkg::CTRL_LOOP_BIT];
  assign pcsConfig.fullDuplex    = s_reg.ctrl[pcsamr_pkg::CTRL_DUPLEX_BIT];
  assign pcsConfig.collisionTest = s_reg.ctrl[pcsamr_pkg::CTRL_COLTEST_BIT];
  assign pcsConfig.advert        = s_reg.advert;
  assign pcsConfig.local_extra_page_tx      = s_reg.local_extra_page_tx;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  AST_SILENT_OUTSIDE_TEN_BIT: assert property (
    !tenBitPhyMode |=> !serialMgmtIoOe
  ) else $error("management data driven outside ten-bit mode");

  AST_OWN_ADDRESS_ONLY: assert property (
    $rose(serialMgmtIoOe) |-> (s_reg.phyAddr == 5'h01) && s_reg.isRead
  ) else $error("read answered at a foreign PHY address");

  AST_TURNAROUND_ZERO: assert property (
    $rose(serialMgmtIoOe) |-> !serialMgmtIoOut && (s_reg.phase == pcsamr_pkg::PH_TA)
  ) else $error("turnaround bit not driven low");

  AST_HOST_OWNS_LINE: assert property (
    serialMgmtDriveBit |=> !serialMgmtIoOe
  ) else $error("device drives while host owns the data line");

  AST_ADV_RESERVED_ZERO: assert property (
    (s_reg.advert & 16'h4E00) == 16'h0000
  ) else $error("reserved advertisement bits not zero");

  AST_ADV_WRITE_TAKES: assert property (
    wrHit && (s_reg.regAddr == 5'h04) |=> s_reg.advert == ($past(wrValue) & 16'hB1E0)
  ) else $error("advertisement write not stored as masked");

  AST_UNUSED_WRITE_IGNORED: assert property (
    wrHit && (s_reg.regAddr inside {5'h02, 5'h03, [5'h09:5'h0E], [5'h10:5'h1F]})
    |=> $stable(s_reg.ctrl) && $stable(s_reg.advert) && $stable(s_reg.local_extra_page_tx)
  ) else $error("write to unused address changed a register");

  AST_UNUSED_READ_ZERO: assert property (
    s_reg.rdStb && (s_reg.regAddr inside {5'h02, 5'h03, [5'h09:5'h0E], [5'h10:5'h1F]})
    |=> rdData == 16'h0000
  ) else $error("unused address read nonzero");

  AST_XSTATUS_READ: assert property (
    s_reg.rdStb && (s_reg.regAddr == 5'h0F) |=> rdData == 16'hC000
  ) else $error("extended status read wrong");

  AST_RESTART_PULSE: assert property (
    wrHit && (s_reg.regAddr == 5'h00) && wrValue[9] && !wrValue[15]
    |=> pcsConfig.anRestart ##1 !pcsConfig.anRestart
  ) else $error("restart not a single pulse");

  AST_PCS_RESET_DEFAULTS: assert property (
    wrHit && (s_reg.regAddr == 5'h00) && wrValue[15]
    |=> (s_reg.advert == 16'h01E0) && (s_reg.ctrl == 16'h1140) && pcsConfig.pcsReset
  ) else $error("sublayer reset did not restore defaults");

  AST_NO_WRITE_OUTSIDE_TEN_BIT: assert property (
    !tenBitPhyMode
    |=> $stable(s_reg.ctrl) && $stable(s_reg.advert) && $stable(s_reg.local_extra_page_tx)
  ) else $error("register changed outside ten-bit mode");

  AST_FOREIGN_WRITE_IGNORED: assert property (
    clkRise && (s_reg.phase == pcsamr_pkg::PH_DATA) && (s_reg.bitCnt == 6'h0F)
    && (s_reg.phyAddr != 5'h01)
    |=> $stable(s_reg.ctrl) && $stable(s_reg.advert) && $stable(s_reg.local_extra_page_tx)
  ) else $error("frame for a foreign PHY address changed a register");

  AST_NEXT_PAGE_TAKES: assert property (
    wrHit && (s_reg.regAddr == 5'h07) |=> s_reg.local_extra_page_tx == $past(wrValue)
  ) else $error("next page write not stored");

  AST_CTRL_SELF_CLEAR: assert property (
    !s_reg.ctrl[15] && !s_reg.ctrl[9]
  ) else $error("self-clearing control bit stored");

  AST_CTRL_FIXED_BITS: assert property (
    (s_reg.ctrl & 16'h2C7F) == 16'h0040
  ) else $error("read-only control bits changed");

  AST_CTRL_WRITE_TAKES: assert property (
    wrHit && (s_reg.regAddr == 5'h00) && !wrValue[15]
    |=> s_reg.ctrl == (($past(wrValue) & 16'h5180) | 16'h0040)
  ) else $error("control write not stored as masked");

  AST_RESET_PULSE_SINGLE: assert property (
    pcsConfig.pcsReset |=> !pcsConfig.pcsReset
  ) else $error("sublayer reset pulse longer than one cycle");

  AST_OE_DROPS_AFTER_FRAME: assert property (
    serialMgmtIoOe && clkFall && (s_reg.phase == pcsamr_pkg::PH_PRE)
    |=> !serialMgmtIoOe
  ) else $error("data line still driven after the last data bit");

endmodule
`default_nettype wire

// ---- rtl/pcsamr_pkg.sv ----
// constants and types of the coding sublayer management register block
package pcsamr_pkg;

  localparam logic [4:0]  PHY_ADDR        = 5'h01;
  localparam logic [4:0]  ADDR_CTRL       = 5'h00;
  localparam logic [4:0]  ADDR_STATUS     = 5'h01;
  localparam logic [4:0]  ADDR_ADVERT     = 5'h04;
  localparam logic [4:0]  ADDR_PBASE      = 5'h05;
  localparam logic [4:0]  ADDR_EXPANSION  = 5'h06;
  localparam logic [4:0]  ADDR_NPAGE      = 5'h07;
  localparam logic [4:0]  ADDR_PNEXT      = 5'h08;
  localparam logic [4:0]  ADDR_XSTATUS    = 5'h0F;

  localparam logic [15:0] RST_CTRL        = 16'h1140;
  localparam logic [15:0] RST_ADVERT      = 16'h01E0;
  localparam logic [15:0] RST_NPAGE       = 16'h0000;
  localparam logic [15:0] GIGABIT_ABILITY = 16'hC000;
  localparam logic [15:0] CTRL_WR_MASK    = 16'hD380;
  localparam logic [15:0] ADV_WR_MASK     = 16'hB1E0;
  localparam logic [15:0] ADV_RSV_MASK    = 16'h4E00;

  localparam int CTRL_RESET_BIT   = 15;
  localparam int CTRL_LOOP_BIT    = 14;
  localparam int CTRL_ANEN_BIT    = 12;
  localparam int CTRL_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT  = 8;
  localparam int CTRL_COLTEST_BIT = 7;
  localparam int STAT_XSTAT_BIT   = 8;
  localparam int STAT_ANDONE_BIT  = 5;
  localparam int STAT_RFAULT_BIT  = 4;
  localparam int STAT_ANABLE_BIT  = 3;
  localparam int STAT_LINK_BIT    = 2;
  localparam int STAT_EXTCAP_BIT  = 0;
  localparam int EXP_NPABLE_BIT   = 2;
  localparam int EXP_PAGERX_BIT   = 1;

  localparam logic [5:0]  PREAMBLE_LEN    = 6'h20;
  localparam logic [1:0]  OP_READ         = 2'h2;
  localparam logic [1:0]  OP_WRITE        = 2'h1;

  typedef enum logic [2:0] {
    PH_PRE,
    PH_START,
    PH_OP,
    PH_PHY,
    PH_REG,
    PH_TA,
    PH_DATA
  } pcsamr_phase_type;

  typedef struct packed {
    logic        linkUp;
    logic        anDone;
    logic        remoteFault;
    logic        pageReceived;
    logic [15:0] partnerBase;
    logic [15:0] partnerNext;
  } pcsamr_status_type;

  typedef struct packed {
    logic        pcsReset;
    logic        anRestart;
    logic        anEnable;
    logic        loopback;
    logic        fullDuplex;
    logic        collisionTest;
    logic [15:0] advert;
    logic [15:0] local_extra_page_tx;
  } pcsamr_cfg_type;

  typedef struct packed {
    pcsamr_phase_type phase;
    logic [5:0]       bitCnt;
    logic [15:0]      shiftIn;
    logic [1:0]       opCode;
    logic [4:0]       phyAddr;
    logic [4:0]       regAddr;
    logic             isRead;
    logic             rdStb;
    logic             dataOut;
    logic             dataOe;
    logic [15:0]      ctrl;
    logic [15:0]      advert;
    logic [15:0]      local_extra_page_tx;
    logic             pcsReset;
    logic             anRestart;
  } pcsamr_frame_type;

  typedef struct packed {
    logic prev;
    logic rise;
    logic fall;
  } pcsamr_edge_type;

endpackage

// ---- rtl/pcsamr_edge.sv ----
// edge pulses of the software-driven management clock bit
`timescale 1ns/10ps
`default_nettype none
module pcsamr_edge (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic mgmtClock,
  output logic      clkRise,
  output logic      clkFall
);

  pcsamr_pkg::pcsamr_edge_type s_reg;
  pcsamr_pkg::pcsamr_edge_type s_next;

  always_comb begin
    s_next      = s_reg;
    s_next.prev = mgmtClock;
    s_next.rise = mgmtClock & ~s_reg.prev;
    s_next.fall = ~mgmtClock & s_reg.prev;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign clkRise = s_reg.rise;
  assign clkFall = s_reg.fall;

endmodule
`default_nettype wire

// ---- rtl/pcsamr_rdmux.sv ----
// registered read selection of the management register map
`timescale 1ns/10ps
`default_nettype none
module pcsamr_rdmux (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          rdStb,
  input  wire logic [4:0]                    rdAddr,
  input  wire logic [15:0]                   ctrl,
  input  wire logic [15:0]                   advert,
  input  wire logic [15:0]                   local_extra_page_tx,
  input  wire pcsamr_pkg::pcsamr_status_type pcsStatus,
  output logic [15:0]                        rdData
);

  logic [15:0] rdData_reg;
  logic [15:0] rdData_next;
  logic [15:0] statusWord;
  logic [15:0] expansionWord;

  always_comb begin
    statusWord                              = 16'h0000;
    statusWord[pcsamr_pkg::STAT_XSTAT_BIT]  = 1'b1;
    statusWord[pcsamr_pkg::STAT_ANDONE_BIT] = pcsStatus.anDone;
    statusWord[pcsamr_pkg::STAT_RFAULT_BIT] = pcsStatus.remoteFault;
    statusWord[pcsamr_pkg::STAT_ANABLE_BIT] = 1'b1;
    statusWord[pcsamr_pkg::STAT_LINK_BIT]   = pcsStatus.linkUp;
    statusWord[pcsamr_pkg::STAT_EXTCAP_BIT] = 1'b1;
    expansionWord                             = 16'h0000;
    expansionWord[pcsamr_pkg::EXP_NPABLE_BIT] = 1'b1;
    expansionWord[pcsamr_pkg::EXP_PAGERX_BIT] = pcsStatus.pageReceived;
    rdData_next = rdData_reg;
    if (rdStb) begin
      case (rdAddr)
        pcsamr_pkg::ADDR_CTRL:      rdData_next = ctrl;
        pcsamr_pkg::ADDR_STATUS:    rdData_next = statusWord;
        pcsamr_pkg::ADDR_ADVERT:    rdData_next = advert;
        pcsamr_pkg::ADDR_PBASE:     rdData_next = pcsStatus.partnerBase;
        pcsamr_pkg::ADDR_EXPANSION: rdData_next = expansionWord;
        pcsamr_pkg::ADDR_NPAGE:     rdData_next = local_extra_page_tx;
        pcsamr_pkg::ADDR_PNEXT:     rdData_next = pcsStatus.partnerNext;
        pcsamr_pkg::ADDR_XSTATUS:   rdData_next = pcsamr_pkg::GIGABIT_ABILITY;
        default:                    rdData_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= 16'h0000;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign rdData = rdData_reg;

endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench of the coding sublayer management register block
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                          sys_clk;
  logic                          rst_b;
  logic                          tenBitPhyMode;
  logic                          serialMgmtClockBit;
  logic                          serialMgmtDriveBit;
  logic                          hostBit;
  wire logic                     serialMgmtIoIn;
  pcsamr_pkg::pcsamr_status_type pcsStatus;
  logic                          serialMgmtIoOut;
  logic                          serialMgmtIoOe;
  pcsamr_pkg::pcsamr_cfg_type    pcsConfig;
  int                            err_total;
  int                            num_checks;
  int                            restartCnt;
  int                            resetCnt;
  int                            seedDummy;
  logic [15:0]                   mCtrl;
  logic [15:0]                   mAdv;
  logic [15:0]                   mNp;
  logic [15:0]                   rd;
  logic [15:0]                   w;
  logic                          oeSeen;
  logic                          taBit;

  // line has a pull-up; device drive wins so contention never hides a device bit
  assign serialMgmtIoIn = serialMgmtIoOe ? serialMgmtIoOut : (serialMgmtDriveBit ? hostBit : 1'b1);

  pcsamr_mgmt_regs DUT (
    .sys_clk            (sys_clk),
    .rst_b              (rst_b),
    .tenBitPhyMode      (tenBitPhyMode),
    .serialMgmtClockBit (serialMgmtClockBit),
    .serialMgmtIoIn     (serialMgmtIoIn),
    .serialMgmtDriveBit (serialMgmtDriveBit),
    .pcsStatus          (pcsStatus),
    .serialMgmtIoOut    (serialMgmtIoOut),
    .serialMgmtIoOe     (serialMgmtIoOe),
    .pcsConfig          (pcsConfig)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk) begin
    if (pcsConfig.anRestart === 1'b1) restartCnt++;
    if (pcsConfig.pcsReset === 1'b1) resetCnt++;
    if (serialMgmtIoOe === 1'b1) oeSeen = 1'b1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
    num_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("FAIL t=%0t %s seen %h expected %h", $time, what, seen, expv);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [15:0] expect_rd(input logic [4:0] a);
    case (a)
      5'h00: return mCtrl;
      5'h01: return {7'h00, 1'b1, 2'h0, pcsStatus.anDone, pcsStatus.remoteFault, 1'b1,
                     pcsStatus.linkUp, 1'b0, 1'b1};
      5'h04: return mAdv;
      5'h05: return pcsStatus.partnerBase;
      5'h06: return {13'h0000, 1'b1, pcsStatus.pageReceived, 1'b0};
      5'h07: return mNp;
      5'h08: return pcsStatus.partnerNext;
      5'h0F: return 16'hC000;
      default: return 16'h0000;
    endcase
  endfunction

  // one clause 22 frame; each mgmt clock half lasts 3 cycles, above the 2 the sampler needs
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, phy, rg, 2'b10, wd};
    oeSeen = 1'b0;
    rdat = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      serialMgmtClockBit <= 1'b0;
      hostBit <= bits[i];
      serialMgmtDriveBit <= !(op == pcsamr_pkg::OP_READ && i < 18);
      repeat (3) @(negedge sys_clk);
      if (i < 16) rdat[i] = serialMgmtIoIn;
      if (i == 16) taBit = serialMgmtIoIn;
      serialMgmtClockBit <= 1'b1;
      repeat (3) @(negedge sys_clk);
    end
    serialMgmtClockBit <= 1'b0;
    serialMgmtDriveBit <= 1'b1;
    hostBit <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check({15'h0000, serialMgmtIoOe}, 16'h0000, "drive released after frame");
  endtask

  task automatic cfgcheck();
    check(pcsConfig.advert, mAdv, "advert level");
    check(pcsConfig.local_extra_page_tx, mNp, "next page level");
    check({12'h000, pcsConfig.anEnable, pcsConfig.loopback, pcsConfig.fullDuplex,
           pcsConfig.collisionTest}, {12'h000, mCtrl[12], mCtrl[14], mCtrl[8], mCtrl[7]},
          "control levels");
  endtask

  task automatic rdreg(input logic [4:0] phy, input logic [4:0] a);
    logic answers;
    answers = (tenBitPhyMode === 1'b1) && (phy == pcsamr_pkg::PHY_ADDR);
    frame(pcsamr_pkg::OP_READ, phy, a, 16'h0000, rd);
    check({15'h0000, oeSeen}, {15'h0000, answers}, "device answer presence");
    if (answers) begin
      check({15'h0000, taBit}, 16'h0000, "turnaround zero");
      check(rd, expect_rd(a), "read data");
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] wv);
    int r0;
    int p0;
    logic live;
    r0 = restartCnt;
    p0 = resetCnt;
    live = (tenBitPhyMode === 1'b1);
    frame(pcsamr_pkg::OP_WRITE, pcsamr_pkg::PHY_ADDR, a, wv, rd);
    if (live && a == 5'h00 && wv[15]) begin
      mCtrl = pcsamr_pkg::RST_CTRL;
      mAdv = 16'h01E0;
      mNp = pcsamr_pkg::RST_NPAGE;
    end else if (live && a == 5'h00) begin
      // reset and restart bits never stay set
      mCtrl = (mCtrl & ~pcsamr_pkg::CTRL_WR_MASK) | (wv & pcsamr_pkg::CTRL_WR_MASK & 16'h7DFF);
    end else if (live && a == 5'h04) begin
      mAdv = (mAdv & 16'h4E1F) | (wv & 16'hB1E0);
    end else if (live && a == 5'h07) begin
      mNp = wv;
    end
    check(16'(restartCnt - r0), {15'h0000, live && a == 5'h00 && !wv[15] && wv[9]},
          "restart pulse count");
    check(16'(resetCnt - p0), {15'h0000, live && a == 5'h00 && wv[15]}, "reset pulse count");
    cfgcheck();
  endtask

  initial begin
    repeat (60000) @(negedge sys_clk);
    err_total++;
    $display("FAIL t=%0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    tenBitPhyMode = 1'b1;
    serialMgmtClockBit = 1'b0;
    serialMgmtDriveBit = 1'b1;
    hostBit = 1'b1;
    pcsStatus = '0;
    err_total = 0;
    num_checks = 0;
    restartCnt = 0;
    resetCnt = 0;
    mCtrl = 16'h1140;
    mAdv = 16'h01E0;
    mNp = pcsamr_pkg::RST_NPAGE;
    seedDummy = $urandom(32'h4B6C1AE6);
    repeat (20) @(negedge sys_clk);
    rst_b = 1'b1;
    @(negedge sys_clk);
    cfgcheck();
    check({15'h0000, serialMgmtIoOe}, 16'h0000, "idle after reset");
    for (int a = 0; a < 32; a++) begin
      pcsStatus <= 36'({$urandom(), $urandom()});
      rdreg(pcsamr_pkg::PHY_ADDR, 5'(a));
    end
    // every remote fault and pause code, reserved bit 14 written as one, other reserved bits random
    for (int k = 0; k < 8; k++) begin
      w = 16'($urandom());
      w[13:12] = 2'(k);
      w[8:7] = 2'(k);
      w[15] = k[2];
      w[14] = 1'b1;
      wr(5'h04, w);
      rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
      wr(5'h07, 16'($urandom()));
      rdreg(pcsamr_pkg::PHY_ADDR, 5'h07);
    end
    for (int a = 0; a < 16; a++) begin
      if (a == 2 || a == 3 || a > 8 && a < 15) begin
        wr(5'(a), 16'hFFFF);
        rdreg(pcsamr_pkg::PHY_ADDR, 5'(a));
      end
    end
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
    // other addresses and a bad opcode leave the bank alone
    frame(pcsamr_pkg::OP_WRITE, 5'h02, 5'h04, ~mAdv, rd);
    frame(pcsamr_pkg::OP_WRITE, 5'h00, 5'h04, ~mAdv, rd);
    frame(2'b11, pcsamr_pkg::PHY_ADDR, 5'h04, ~mAdv, rd);
    cfgcheck();
    rdreg(5'h02, 5'h04);
    // blocking, so the model sees the new mode in this same step
    tenBitPhyMode = 1'b0;
    wr(5'h04, ~mAdv);
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
    tenBitPhyMode = 1'b1;
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
    wr(5'h00, 16'h0200);
    wr(5'h00, 16'($urandom()) & 16'h7FFF);
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h00);
    wr(5'h00, 16'hFFFF);
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h00);
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
    // second reset in mid-run restores defaults
    wr(5'h04, 16'h0000);
    rst_b <= 1'b0;
    repeat (3) @(negedge sys_clk);
    mCtrl = 16'h1140;
    mAdv = 16'h01E0;
    mNp = pcsamr_pkg::RST_NPAGE;
    cfgcheck();
    rst_b <= 1'b1;
    @(negedge sys_clk);
    rdreg(pcsamr_pkg::PHY_ADDR, 5'h04);
    finish_test();
  end
endmodule
`default_nettype wire
